// *** verilog/timer_consts.vh ***
// register offsets, field positions and reset values of the low-power timer
// assumes a 32-bit classic wishbone slave with byte addressing
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// register byte offsets
`define OFF_CTRL 8'h00
`define OFF_FLAGS 8'h04
`define OFF_MODULO 8'h08
`define OFF_COUNT 8'h0C
`define OFF_CH0_CTRL 8'h10
`define OFF_CH1_CTRL 8'h14
`define OFF_CH0_VAL 8'h18
`define OFF_CH1_VAL 8'h1C
`define OFF_EV_STATUS 8'h20
`define OFF_EV_CLEAR 8'h24
`define OFF_EV_ENABLE 8'h28

// control register fields
`define CTRL_OVF_IE 0
`define CTRL_HALT 1
`define CTRL_CNT_CLR 2

// channel control register fields
`define CH_COMPARE 0
`define CH_IE 1

// flag and event bit positions
`define FLAG_OVF 0
`define FLAG_CH0 1
`define FLAG_CH1 2

// reset values
`define RST_CTRL 3'h0
`define RST_MODULO 16'hFFFF
`define RST_COUNT 16'h0000
`define RST_CH_CTRL 2'h0
`define RST_CH_VAL 16'h0000
`define RST_FLAGS 3'h0

`endif

// *** verilog/sync_2ff.v ***
// two flip-flop synchroniser for asynchronous level inputs
// assumes a single destination clock; the first stage feeds only the second
`timescale 1ns/1ps

module sync_2ff #(
    parameter WIDTH = 1
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // data
    input wire [WIDTH-1:0] d_i,
    output reg [WIDTH-1:0] q_o
);

reg [WIDTH-1:0] stage1;

always @(posedge clk_i) begin
    if (rst_i) begin
        stage1 <= {WIDTH{1'b0}};
        q_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
        stage1 <= d_i;
        q_o <= stage1;
    end
end

endmodule // sync_2ff

// *** verilog/timer_lowpower_break_control.v ***
// general timer with low-power and debug-break handling, wishbone slave
// assumes wait, stop and break levels come from the system unit on clk_i;
// capture pins are asynchronous and are synchronised here
//
// Contract
// R1 - channel request reaches interrupt only when channel_irq_enable is 1; flag still sets; here ev_enable also passes channel events to irq_o
// R2 - channel_event_flag sets on input capture or output compare
// R3 - counter_overflow_flag sets at modulo; requests only with overflow_irq_enable; here ev_enable bit 0 also passes overflow to irq_o
// R4 - counter keeps running in wait mode
// R5 - registers not accessible by the processor during wait mode
// R6 - any enabled timer request wakes the system from wait mode
// R7 - software should halt the timer before wait when unused, saving power
// R8 - timer inactive, counter stopped, in stop mode
// R9 - stop mode leaves every register unchanged
// R10 - timer resumes from retained state when stop mode ends
// R11 - reset during stop returns the timer to its reset state
// R12 - counter halts while debug break is active
// R13 - with break_flag_clear_enable 1 flags clear normally during break
// R14 - a flag cleared in break stays cleared after break
// R15 - with break_flag_clear_enable 0 break accesses never change flags
// R16 - first clear step done before break does not clear flag during protected break
// R17 - second clear step after break clears flag normally
// R18 - break_flag_clear_enable is an input from the system integration unit
// R19 - interrupt is OR of enabled overflow and channel requests, held until cleared
`timescale 1ns/1ps
`include "timer_consts.vh"

module timer_lowpower_break_control (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // system integration unit
    input wire wait_mode_i,
    input wire stop_mode_i,
    input wire break_i,
    input wire break_flag_clear_enable_i,
    // capture pins
    input wire [1:0] capture_pin_i,
    // interrupt and wake
    output reg irq_o,
    output reg wake_o
);

// bus decode
wire bus_req = cyc_i & stb_i & ~ack_o & ce_i;
wire bus_open = bus_req & ~wait_mode_i; // [R5]
// writes land at the acknowledging edge, where the master samples ack
wire wr = cyc_i & stb_i & ack_o & ce_i & we_i & ~wait_mode_i; // [R5]
wire rd = bus_open & ~we_i;
wire [7:0] word_adr = {adr_i[7:2], 2'b00};

// break protection of flags
wire allow_clear = ~break_i | break_flag_clear_enable_i; // [R13] [R15] [R18]

// control state
reg ovf_ie;
reg halt;
reg [15:0] modulo;
reg [15:0] count;
reg [2:0] flags;
reg [2:0] armed;
reg [2:0] ev_status;
reg [2:0] ev_enable;

// counter runs unless stopped, in break or halted by software
wire run = ~stop_mode_i & ~break_i & ~halt; // [R4] [R8] [R12]
wire ovf_hit = run & (count == modulo); // [R3]

// per-channel buses
wire [31:0] ch_val_bus;
wire [3:0] ch_cfg_bus;
wire [1:0] ch_hit;
wire [1:0] pin_sync;

sync_2ff #(
    .WIDTH(2)
) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(capture_pin_i),
    .q_o(pin_sync)
);

function [15:0] merge16;
    input [15:0] old;
    input [15:0] new_val;
    input [1:0] lanes;
    begin
        merge16 = {lanes[1] ? new_val[15:8] : old[15:8],
                   lanes[0] ? new_val[7:0] : old[7:0]};
    end
endfunction

genvar i;
generate
    for (i = 0; i < 2; i = i + 1) begin : gen_ch
        reg [15:0] val;
        reg [1:0] cfg;
        reg pin_d;
        wire is_cmp = cfg[`CH_COMPARE];
        wire cap_edge = pin_sync[i] & ~pin_d & ~is_cmp & ~stop_mode_i;
        wire cmp_hit = is_cmp & run & (count == val);
        wire sel_ctrl = (word_adr == (i == 0 ? `OFF_CH0_CTRL : `OFF_CH1_CTRL));
        wire sel_val = (word_adr == (i == 0 ? `OFF_CH0_VAL : `OFF_CH1_VAL));

        assign ch_hit[i] = cap_edge | cmp_hit; // [R2]
        assign ch_val_bus[i*16 +: 16] = val;
        assign ch_cfg_bus[i*2 +: 2] = cfg;

        always @(posedge clk_i) begin
            if (rst_i) begin // [R11]
                val <= `RST_CH_VAL;
                cfg <= `RST_CH_CTRL;
                pin_d <= 1'b0;
            end else if (ce_i) begin
                pin_d <= pin_sync[i];
                if (cap_edge) begin
                    val <= count; // [R2]
                end else if (wr && sel_val) begin
                    val <= merge16(val, dat_i[15:0], sel_i[1:0]);
                end
                if (wr && sel_ctrl && sel_i[0]) begin
                    cfg <= dat_i[1:0];
                end
            end
        end
    end
endgenerate

wire [2:0] flag_set = {ch_hit, ovf_hit};
wire [2:0] native_en = {ch_cfg_bus[2 + `CH_IE], ch_cfg_bus[`CH_IE], ovf_ie};
wire rd_flags = rd & (word_adr == `OFF_FLAGS);
wire wr_flags = wr & (word_adr == `OFF_FLAGS) & sel_i[0];

// two-step flag clearing: read with flag set arms, write of 0 clears
genvar k;
generate
    for (k = 0; k < 3; k = k + 1) begin : gen_flag
        wire do_clear = allow_clear & armed[k] & wr_flags & ~dat_i[k]; // [R16] [R17]
        always @(posedge clk_i) begin
            if (rst_i) begin
                flags[k] <= 1'b0;
                armed[k] <= 1'b0;
            end else if (ce_i) begin
                // set wins over a clear in the same cycle
                flags[k] <= flag_set[k] | (flags[k] & ~do_clear); // [R13] [R14] [R15]
                if (do_clear || !flags[k]) begin
                    armed[k] <= 1'b0;
                end else if (allow_clear && rd_flags) begin
                    armed[k] <= 1'b1; // [R15]
                end
            end
        end
    end
endgenerate

// counter and control
always @(posedge clk_i) begin
    if (rst_i) begin // [R11]
        ovf_ie <= 1'b0;
        halt <= 1'b0;
        modulo <= `RST_MODULO;
        count <= `RST_COUNT;
    end else if (ce_i) begin
        if (wr && word_adr == `OFF_CTRL && sel_i[0]) begin
            ovf_ie <= dat_i[`CTRL_OVF_IE];
            halt <= dat_i[`CTRL_HALT];
        end
        if (wr && word_adr == `OFF_MODULO) begin
            modulo <= merge16(modulo, dat_i[15:0], sel_i[1:0]);
        end
        // stop and break only freeze the count, state is kept
        if (wr && word_adr == `OFF_CTRL && sel_i[0] && dat_i[`CTRL_CNT_CLR]) begin
            count <= `RST_COUNT;
        end else if (ovf_hit) begin
            count <= `RST_COUNT; // [R3]
        end else if (run) begin
            count <= count + 16'h0001; // [R4] [R9] [R10]
        end
    end
end

// sticky event status for the interrupt group
always @(posedge clk_i) begin
    if (rst_i) begin
        ev_status <= `RST_FLAGS;
        ev_enable <= `RST_FLAGS;
    end else if (ce_i) begin
        // protected break keeps the sticky events as well
        if (wr && allow_clear && word_adr == `OFF_EV_CLEAR && sel_i[0]) begin // [R13] [R15]
            ev_status <= flag_set | (ev_status & ~dat_i[2:0]);
        end else begin
            ev_status <= flag_set | ev_status;
        end
        if (wr && word_adr == `OFF_EV_ENABLE && sel_i[0]) begin
            ev_enable <= dat_i[2:0];
        end
    end
end

// interrupt and wake request
wire native_req = |(flags & native_en); // [R1] [R3] [R19]
wire ev_req = |(ev_status & ev_enable);

always @(posedge clk_i) begin
    if (rst_i) begin
        irq_o <= 1'b0;
        wake_o <= 1'b0;
    end else if (ce_i) begin
        irq_o <= native_req | ev_req; // [R19]
        wake_o <= wait_mode_i & (native_req | ev_req); // [R6]
    end
end

// read mux
reg [31:0] rdata;
always @* begin
    rdata = 32'h00000000;
    case (word_adr)
        `OFF_CTRL: rdata = {30'h00000000, halt, ovf_ie};
        `OFF_FLAGS: rdata = {29'h00000000, flags};
        `OFF_MODULO: rdata = {16'h0000, modulo};
        `OFF_COUNT: rdata = {16'h0000, count};
        `OFF_CH0_CTRL: rdata = {30'h00000000, ch_cfg_bus[1:0]};
        `OFF_CH1_CTRL: rdata = {30'h00000000, ch_cfg_bus[3:2]};
        `OFF_CH0_VAL: rdata = {16'h0000, ch_val_bus[15:0]};
        `OFF_CH1_VAL: rdata = {16'h0000, ch_val_bus[31:16]};
        `OFF_EV_STATUS: rdata = {29'h00000000, ev_status};
        `OFF_EV_ENABLE: rdata = {29'h00000000, ev_enable};
        default: rdata = 32'h00000000;
    endcase
end

// wishbone answer: one cycle, also in wait mode so the master never hangs
always @(posedge clk_i) begin
    if (rst_i) begin
        ack_o <= 1'b0;
        dat_o <= 32'h00000000;
    end else if (ce_i) begin
        ack_o <= bus_req;
        if (rd) begin
            dat_o <= rdata;
        end else if (bus_req) begin
            dat_o <= 32'h00000000; // [R5]
        end
    end
end

endmodule // timer_lowpower_break_control

// *** test/timer_chk.sv ***
// checker for the timer bus answer, interrupt and wake outputs
// assumes one clock, synchronous active-high reset, ce_i high while reset is held
`timescale 1ns/1ps
module timer_chk (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // bus
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // modes and interrupt
    input wire wait_mode_i,
    input wire irq_o,
    input wire wake_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_one_cycle: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack longer than one cycle");
    a_ack_after_req: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("request not acked in the next cycle");
    a_ack_has_req: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    a_read_data_holds: assert property (!$stable(dat_o) |-> ack_o)
        else $error("read data changed without ack");
    a_wait_read_zero: assert property (ack_o && $past(wait_mode_i && !we_i) |-> dat_o == 0)
        else $error("read in wait mode returned data");
    a_wake_from_irq: assert property (ce_i && $past(ce_i) |->
        wake_o == (irq_o && $past(wait_mode_i))) else $error("wake does not follow irq in wait");
    a_wake_in_wait: assert property (wake_o |-> $past(wait_mode_i))
        else $error("wake outside wait mode");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i && ce_i |=>
        !ack_o && !irq_o && !wake_o && dat_o == 0) else $error("outputs not cleared by reset");
    c_wake: cover property (wake_o);
    c_irq_rise: cover property ($rose(irq_o));
    c_write: cover property (ack_o && we_i);
endmodule // timer_chk

bind timer_lowpower_break_control timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
    .wait_mode_i(wait_mode_i), .irq_o(irq_o), .wake_o(wake_o));

// *** test/tb.sv ***
// self-checking bench for the timer with low-power and break flag handling
// assumes the bound checker and a 40 MHz clock
`timescale 1ns/1ps
`include "timer_consts.vh"
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, r, c;
    logic ack_o, irq_o, wake_o;
    logic wait_mode_i = 1'b0, stop_mode_i = 1'b0, break_i = 1'b0, break_flag_clear_enable_i = 1'b0;
    logic [1:0] capture_pin_i = 2'h0;
    int n_errors = 0, check_count = 0;
    always #12.5 clk_i = ~clk_i;
    timer_lowpower_break_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .wait_mode_i(wait_mode_i), .stop_mode_i(stop_mode_i), .break_i(break_i),
        .break_flag_clear_enable_i(break_flag_clear_enable_i), .capture_pin_i(capture_pin_i),
        .irq_o(irq_o), .wake_o(wake_o));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (k >= 20) chk("ack", 32'h0, 32'h1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), r, e);
    endtask
    task automatic ci(input logic e, input logic w);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, irq_o}, {31'h0, e});
        chk("wake", {31'h0, wake_o}, {31'h0, w});
    endtask
    // order: wait, stop, break, break flag clear enable
    task automatic md(input logic [3:0] m);
        @(posedge clk_i);
        {wait_mode_i, stop_mode_i, break_i, break_flag_clear_enable_i} <= m;
    endtask
    task automatic cap(input int i);
        @(posedge clk_i);
        capture_pin_i[i] <= 1'b1;
        repeat (4) @(posedge clk_i);
        capture_pin_i[i] <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic t_ovf;
        rc(`OFF_CTRL, 32'h0);
        rc(`OFF_MODULO, 32'hFFFF);
        rc(8'h30, 32'h0);
        wb(1'b1, `OFF_MODULO, 32'h10);
        repeat (40) @(posedge clk_i);
        rc(`OFF_FLAGS, 32'h1);
        ci(1'b0, 1'b0);
        wb(1'b1, `OFF_CTRL, 32'h3);
        ci(1'b1, 1'b0);
        rc(`OFF_FLAGS, 32'h1);
        wb(1'b1, `OFF_FLAGS, 32'h0);
        rc(`OFF_FLAGS, 32'h0);
        ci(1'b0, 1'b0);
    endtask
    task automatic t_chan;
        wb(1'b1, `OFF_CTRL, 32'h2);
        cap(0);
        rc(`OFF_FLAGS, 32'h2);
        ci(1'b0, 1'b0);
        wb(1'b1, `OFF_CH0_CTRL, 32'h2);
        ci(1'b1, 1'b0);
        wb(1'b1, `OFF_CH1_VAL, 32'h5);
        wb(1'b1, `OFF_CH1_CTRL, 32'h1);
        wb(1'b1, `OFF_CTRL, 32'h0);
        repeat (40) @(posedge clk_i);
        wb(1'b1, `OFF_CTRL, 32'h2);
        rc(`OFF_FLAGS, 32'h7);
    endtask
    task automatic t_break;
        md(4'b0010);
        wb(1'b1, `OFF_FLAGS, 32'h0);
        rc(`OFF_FLAGS, 32'h7);
        md(4'b0000);
        wb(1'b1, `OFF_FLAGS, 32'h0);
        rc(`OFF_FLAGS, 32'h0);
        cap(0);
        md(4'b0011);
        rc(`OFF_FLAGS, 32'h2);
        wb(1'b1, `OFF_FLAGS, 32'h0);
        rc(`OFF_FLAGS, 32'h0);
        md(4'b0000);
        rc(`OFF_FLAGS, 32'h0);
    endtask
    task automatic t_events;
        rc(`OFF_EV_STATUS, 32'h7);
        md(4'b0010);
        wb(1'b1, `OFF_EV_CLEAR, 32'h7);
        md(4'b0000);
        rc(`OFF_EV_STATUS, 32'h7);
        wb(1'b1, `OFF_EV_CLEAR, 32'h1);
        rc(`OFF_EV_STATUS, 32'h6);
        wb(1'b1, `OFF_EV_ENABLE, 32'h4);
        ci(1'b1, 1'b0);
        wb(1'b1, `OFF_EV_CLEAR, 32'h4);
        rc(`OFF_EV_STATUS, 32'h2);
        ci(1'b0, 1'b0);
        wb(1'b1, `OFF_EV_ENABLE, 32'h0);
    endtask
    task automatic t_low;
        wb(1'b1, `OFF_MODULO, 32'h1000);
        wb(1'b1, `OFF_CTRL, 32'h0);
        md(4'b0010);
        wb(1'b0, `OFF_COUNT, 32'h0);
        c = r;
        rc(`OFF_COUNT, c);
        md(4'b0100);
        rc(`OFF_COUNT, c);
        rc(`OFF_MODULO, 32'h1000);
        md(4'b0000);
        repeat (3) @(posedge clk_i);
        wb(1'b0, `OFF_COUNT, 32'h0);
        chk("count resumes", {31'h0, r > c}, 32'h1);
        cap(0);
        wb(1'b0, `OFF_COUNT, 32'h0);
        c = r;
        md(4'b1000);
        ci(1'b1, 1'b1);
        wb(1'b1, `OFF_MODULO, 32'h20);
        rc(`OFF_MODULO, 32'h0);
        repeat (30) @(posedge clk_i);
        md(4'b0000);
        rc(`OFF_MODULO, 32'h1000);
        wb(1'b0, `OFF_COUNT, 32'h0);
        chk("count in wait", {31'h0, r > c + 32'd30}, 32'h1);
        wb(1'b1, `OFF_CTRL, 32'h2);
        wb(1'b0, `OFF_COUNT, 32'h0);
        c = r;
        md(4'b1000);
        repeat (10) @(posedge clk_i);
        md(4'b0000);
        rc(`OFF_COUNT, c);
        md(4'b0100);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        md(4'b0000);
        rc(`OFF_MODULO, 32'hFFFF);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_ovf;
        t_chan;
        t_break;
        t_events;
        t_low;
        finish_test;
    end
    initial begin
        #100us;
        n_errors++;
        finish_test;
    end
endmodule // tb
